// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import volume_ctrl_pkg::*;
;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [15:0]       reg_addr = 16'h0000;
    logic              reg_wr = 1'b0;
    logic [15:0]       reg_wdata = 16'h0000;
    logic              reg_rd = 1'b0;
    logic [15:0]       reg_rdata;
    logic [2:0]        rise_rate = 3'h0;
    logic [2:0]        fall_rate = 3'h0;
    logic [2:0]        mic_en = 3'h0;
    logic [2:0]        pd_on;
    logic [59:0]       level;
    logic [5:0]        silenced;
    int                error_cnt = 0;
    int                n_compared = 0;
    int                n;
    int                m;
    // fine-step ticks per rate code, ramp time per 6 dB over 0.5 ms
    int                mult_exp [8] = '{0, 1, 2, 4, 8, 16, 30, 60};
    logic [15:0]       offs [6] = '{16'h0311, 16'h0315, 16'h0319, 16'h031d, 16'h0321, 16'h0325};

    input_path_digital_volume_ctrl #(.STEP_CYCLES(4)) input_path_digital_volume_ctrl_inst (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gain_rise_ramp_rate(rise_rate),
        .gain_fall_ramp_rate(fall_rate), .mic_path_enable(mic_en),
        .mic_data_pulldown_on(pd_on), .path_gain_level(level), .path_silenced(silenced));

    initial
        forever #5 clk = ~clk;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // each access spans two falling edges so strobes never toggle twice at once
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk("rdata", reg_rdata, exp);
    endtask : rd

    task automatic wait_lvl(input logic [9:0] exp, output int cnt);
        cnt = 0;
        while (level[9:0] !== exp)
        begin
            @(negedge clk);
            cnt++;
            if (cnt > 2000)
            begin
                chk("ramp_wait", 16'h0001, 16'h0000);
                close_out();
            end
        end
    endtask : wait_lvl

    initial
    begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 6; i++)
            rd(offs[i], 16'h0180);
        rd(MIC_DATA_PAD_PULLDOWN_OFFS, 16'h0000);
        chk("silenced", {10'h000, silenced}, 16'h003f);
        for (int i = 0; i < 6; i++)
            wr(offs[i], {8'h00, 8'h1f + 8'h20 * i[7:0]});
        chk("level", level[15:0], 16'h0000);
        wr(offs[0], 16'h021f);
        repeat (3) @(negedge clk);
        for (int i = 0; i < 6; i++)
        begin
            chk("level", {6'h00, level[i*10 +: 10]}, {6'h00, 8'h1f + 8'h20 * i[7:0], 2'b00});
            rd(offs[i], {8'h00, 8'h1f + 8'h20 * i[7:0]});
        end
        chk("silenced", {10'h000, silenced}, 16'h0000);
        rise_rate = 3'h1;
        fall_rate = 3'h2;
        wr(offs[5], 16'h02bf);
        wr(offs[0], 16'h0220);
        wait_lvl(10'h080, n);
        chk("rise_time", 16'(n >= 7 && n <= 20), 16'h0001);
        wr(offs[0], 16'h021f);
        wait_lvl(10'h07c, n);
        chk("fall_time", 16'(n >= 22 && n <= 40), 16'h0001);
        for (int r = 1; r < 8; r++)
        begin
            rise_rate = r[2:0];
            fall_rate = r[2:0];
            m = 16 * mult_exp[r];
            wr(offs[0], 16'h0220);
            wait_lvl(10'h080, n);
            chk("rate_rise", 16'(n >= m - 4 && n <= m + 1), 16'h0001);
            wr(offs[0], 16'h021f);
            wait_lvl(10'h07c, n);
            chk("rate_fall", 16'(n >= m - 4 && n <= m + 1), 16'h0001);
        end
        rise_rate = 3'h0;
        fall_rate = 3'h0;
        wr(offs[0], 16'h031f);
        wr(offs[2], 16'h0380);
        repeat (3) @(negedge clk);
        chk("silenced", {10'h000, silenced}, 16'h0005);
        mic_en = 3'h5;
        wr(MIC_DATA_PAD_PULLDOWN_OFFS, 16'hfff7);
        chk("pulldown", {13'h0000, pd_on}, 16'h0005);
        rd(MIC_DATA_PAD_PULLDOWN_OFFS, 16'h0007);
        mic_en = 3'h2;
        repeat (2) @(negedge clk);
        chk("pulldown", {13'h0000, pd_on}, 16'h0002);
        wr(MIC_DATA_PAD_PULLDOWN_OFFS, 16'h0000);
        chk("pulldown", {13'h0000, pd_on}, 16'h0000);
        wr(16'h0fff, 16'hffff);
        rd(16'h0fff, 16'h0000);
        close_out();
    end
endmodule : tb_top
`default_nettype wire

// File: dv/volume_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module volume_ctrl_props
    import volume_ctrl_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_BASE_STEP_CYCLES
)
(
    input wire logic                         clk,
    input wire logic                         rstn,
    input wire logic [ADDR_W-1:0]            reg_addr,
    input wire logic                         reg_wr,
    input wire logic [DATA_W-1:0]            reg_wdata,
    input wire logic                         reg_rd,
    input wire logic [DATA_W-1:0]            reg_rdata,
    input wire logic [2:0]                   gain_rise_ramp_rate,
    input wire logic [2:0]                   gain_fall_ramp_rate,
    input wire logic [NUM_MIC_PINS-1:0]      mic_path_enable,
    input wire logic [NUM_MIC_PINS-1:0]      mic_data_pulldown_on,
    input wire logic [NUM_PATHS*LEVEL_W-1:0] path_gain_level,
    input wire logic [NUM_PATHS-1:0]         path_silenced
);
    logic vu_wr;
    logic rate0;
    assign vu_wr = reg_wr && reg_wdata[UPDATE_STROBE_BIT] && reg_addr[15:8] == 8'h03;
    assign rate0 = gain_rise_ramp_rate == 3'h0 && gain_fall_ramp_rate == 3'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_pd_off_disabled: assert property ((mic_data_pulldown_on & ~$past(mic_path_enable)) == 3'h0)
        else $error("pulldown on while its path is disabled");
    a_pd_write_follows: assert property (reg_wr && reg_addr == MIC_DATA_PAD_PULLDOWN_OFFS |=>
        mic_data_pulldown_on == ($past(reg_wdata[2:0]) & $past(mic_path_enable)))
        else $error("pulldown does not follow written enables");
    a_strobe_reads_zero: assert property (reg_rd |=> reg_rdata[15:9] == 7'h00)
        else $error("strobe or upper bits read nonzero");
    a_pd_upper_zero: assert property (reg_rd && reg_addr == MIC_DATA_PAD_PULLDOWN_OFFS |=>
        reg_rdata[15:3] == 13'h0000) else $error("pad register upper bits nonzero");
    a_silenced_level: assert property (path_silenced[0] |-> path_gain_level[9:0] == 10'h000)
        else $error("path silenced with nonzero level");
    a_mute_silences: assert property (rate0 && vu_wr && reg_addr == PATH1_LEFT_VOLUME_OFFS
        && reg_wdata[MUTE_BIT] ##1 rate0 && !vu_wr |-> ##2 path_silenced[0])
        else $error("muted path not silenced after update");
    a_fine_step: assert property (!rate0 && $changed(path_gain_level[9:0]) |->
        path_gain_level[9:0] - $past(path_gain_level[9:0]) inside {10'h001, 10'h3ff})
        else $error("ramp step larger than one fine step");
    a_hold_no_strobe: assert property (rate0 && !vu_wr ##1 rate0 && !vu_wr ##1 rate0 && !vu_wr
        |=> $stable(path_gain_level)) else $error("level moved without update strobe");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    c_strobe: cover property (vu_wr);
    c_pulldown: cover property (mic_data_pulldown_on != 3'h0);
    c_unmute: cover property ($fell(path_silenced[0]));
endmodule : volume_ctrl_props
bind input_path_digital_volume_ctrl volume_ctrl_props #(.STEP_CYCLES(STEP_CYCLES)) props_inst (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gain_rise_ramp_rate(gain_rise_ramp_rate),
    .gain_fall_ramp_rate(gain_fall_ramp_rate), .mic_path_enable(mic_path_enable),
    .mic_data_pulldown_on(mic_data_pulldown_on), .path_gain_level(path_gain_level),
    .path_silenced(path_silenced));
`default_nettype wire

// File: hw/gain_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module gain_ramp
    import volume_ctrl_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    gain_ramp_if.ramp rif
);
    typedef struct packed {
        logic [LEVEL_W-1:0] level;
        logic [LEVEL_W-1:0] target;
        logic               mute;
        logic [MULT_W-1:0]  cnt;
    } ramp_state_t;

    ramp_state_t state_reg;
    ramp_state_t state_next;

    always_comb
    begin
        logic [MULT_W-1:0] mult;
        logic              rising;
        state_next = state_reg;
        rising = state_reg.target > state_reg.level;
        mult = rising ? ramp_mult(rif.rise_rate) : ramp_mult(rif.fall_rate);
        if (rif.apply)
        begin
            state_next.mute = rif.staged_mute;
            state_next.target = rif.staged_mute ? '0
                : LEVEL_W'({2'b00, rif.staged_gain} << FINE_SHIFT);
            state_next.cnt = '0;
        end
        else if (state_reg.level != state_reg.target)
        begin
            if (mult == '0)
            begin
                state_next.level = state_reg.target;
            end
            else if (rif.base_tick)
            begin
                if (state_reg.cnt + 6'h01 >= mult)
                begin
                    state_next.cnt = '0;
                    state_next.level = rising ? state_reg.level + 10'h001
                        : state_reg.level - 10'h001;
                end
                else
                begin
                    state_next.cnt = state_reg.cnt + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg.level <= '0;
            state_reg.target <= '0;
            state_reg.mute <= MUTE_RESET;
            state_reg.cnt <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rif.level = state_reg.level;
    assign rif.silenced = state_reg.mute && (state_reg.level == '0);
endmodule : gain_ramp
`default_nettype wire

// File: hw/input_path_digital_volume_ctrl.sv
// Notes on behaviour
// - the 8-bit gain code is linear, 00h is -64 dB, 80h is 0 dB, BFh is +31.5 dB, reset 80h.
// - each of the six paths has a mute bit at bit 8, 1 silences, reset muted.
// - writing 1 to bit 9 of any path volume register applies all staged settings at once.
// - pull-down enables for the three mic data pins sit at bits 2, 1 and 0, independently.
// - an enable of 1 turns the pull-down on, 0 off, and each resets to 0.
// - a pin's pull-down turns off at the clock edge after its mic input path is disabled and stays off while disabled.
// - without the strobe new values are only stored and active gain does not change.
// - applied changes ramp, rises at the rise rate and falls at the fall rate.
// - the internal gain moves in 0.125 dB steps.
`timescale 1ns/1ps
`default_nettype none
module input_path_digital_volume_ctrl
    import volume_ctrl_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_BASE_STEP_CYCLES
)
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [DATA_W-1:0]      reg_wdata,
    input  wire logic                   reg_rd,
    output logic [DATA_W-1:0]           reg_rdata,
    input  wire logic [2:0]             gain_rise_ramp_rate,
    input  wire logic [2:0]             gain_fall_ramp_rate,
    input  wire logic [NUM_MIC_PINS-1:0] mic_path_enable,
    output logic [NUM_MIC_PINS-1:0]     mic_data_pulldown_on,
    output logic [NUM_PATHS*LEVEL_W-1:0] path_gain_level,
    output logic [NUM_PATHS-1:0]        path_silenced
);
    typedef struct packed {
        logic [NUM_PATHS-1:0][7:0]    gain;
        logic [NUM_PATHS-1:0]         mute;
        logic [NUM_MIC_PINS-1:0]      pd_en;
        logic [NUM_MIC_PINS-1:0]      pd_on;
        logic                         apply;
        logic [TICK_CNT_W-1:0]        div;
        logic                         tick;
        logic [DATA_W-1:0]            rdata;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    localparam logic [NUM_PATHS-1:0][ADDR_W-1:0] PATH_OFFS = {
        PATH3_RIGHT_VOLUME_OFFS, PATH3_LEFT_VOLUME_OFFS,
        PATH2_RIGHT_VOLUME_OFFS, PATH2_LEFT_VOLUME_OFFS,
        PATH1_RIGHT_VOLUME_OFFS, PATH1_LEFT_VOLUME_OFFS
    };
    localparam logic [TICK_CNT_W-1:0] DIV_LAST = TICK_CNT_W'(STEP_CYCLES - 1);

    gain_ramp_if rif[NUM_PATHS] ();

    always_comb
    begin
        state_next = state_reg;
        state_next.apply = 1'b0;
        state_next.tick = 1'b0;
        if (state_reg.div == DIV_LAST)
        begin
            state_next.div = '0;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.div = state_reg.div + 11'h001;
        end
        for (int i = 0; i < NUM_PATHS; i++)
        begin
            if (reg_wr && reg_addr == PATH_OFFS[i])
            begin
                state_next.gain[i] = reg_wdata[GAIN_CODE_LSB +: GAIN_CODE_W];
                state_next.mute[i] = reg_wdata[MUTE_BIT];
                state_next.apply = reg_wdata[UPDATE_STROBE_BIT];
            end
        end
        if (reg_wr && reg_addr == MIC_DATA_PAD_PULLDOWN_OFFS)
        begin
            state_next.pd_en = reg_wdata[NUM_MIC_PINS-1:0];
        end
        state_next.pd_on = state_next.pd_en & mic_path_enable;
        if (reg_rd)
        begin
            state_next.rdata = '0;
            for (int i = 0; i < NUM_PATHS; i++)
            begin
                if (reg_addr == PATH_OFFS[i])
                begin
                    state_next.rdata = {7'h00, state_reg.mute[i], state_reg.gain[i]};
                end
            end
            if (reg_addr == MIC_DATA_PAD_PULLDOWN_OFFS)
            begin
                state_next.rdata = {13'h0000, state_reg.pd_en};
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg.gain <= {NUM_PATHS{GAIN_CODE_RESET}};
            state_reg.mute <= {NUM_PATHS{MUTE_RESET}};
            state_reg.pd_en <= PULLDOWN_RESET;
            state_reg.pd_on <= PULLDOWN_RESET;
            state_reg.apply <= 1'b0;
            state_reg.div <= '0;
            state_reg.tick <= 1'b0;
            state_reg.rdata <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    for (genvar g = 0; g < NUM_PATHS; g++)
    begin : g_path
        assign rif[g].staged_gain = state_reg.gain[g];
        assign rif[g].staged_mute = state_reg.mute[g];
        assign rif[g].apply = state_reg.apply;
        assign rif[g].base_tick = state_reg.tick;
        assign rif[g].rise_rate = gain_rise_ramp_rate;
        assign rif[g].fall_rate = gain_fall_ramp_rate;
        assign path_gain_level[g*LEVEL_W +: LEVEL_W] = rif[g].level;
        assign path_silenced[g] = rif[g].silenced;

        gain_ramp u_ramp (
            .clk  (clk),
            .rstn (rstn),
            .rif  (rif[g])
        );
    end

    assign reg_rdata = state_reg.rdata;
    assign mic_data_pulldown_on = state_reg.pd_on;
endmodule : input_path_digital_volume_ctrl
`default_nettype wire

// File: inc/gain_ramp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gain_ramp_if;
    logic [7:0] staged_gain;
    logic       staged_mute;
    logic       apply;
    logic       base_tick;
    logic [2:0] rise_rate;
    logic [2:0] fall_rate;
    logic [9:0] level;
    logic       silenced;

    modport ctrl (output staged_gain, staged_mute, apply, base_tick, rise_rate, fall_rate,
                  input level, silenced);
    modport ramp (input staged_gain, staged_mute, apply, base_tick, rise_rate, fall_rate,
                  output level, silenced);
endinterface : gain_ramp_if
`default_nettype wire

// File: inc/volume_ctrl_pkg.sv
`default_nettype none
package volume_ctrl_pkg;
    localparam int NUM_PATHS = 6;
    localparam int NUM_MIC_PINS = 3;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LEVEL_W = 10;

    localparam logic [ADDR_W-1:0] PATH1_LEFT_VOLUME_OFFS  = 16'h0311;
    localparam logic [ADDR_W-1:0] PATH1_RIGHT_VOLUME_OFFS = 16'h0315;
    localparam logic [ADDR_W-1:0] PATH2_LEFT_VOLUME_OFFS  = 16'h0319;
    localparam logic [ADDR_W-1:0] PATH2_RIGHT_VOLUME_OFFS = 16'h031d;
    localparam logic [ADDR_W-1:0] PATH3_LEFT_VOLUME_OFFS  = 16'h0321;
    localparam logic [ADDR_W-1:0] PATH3_RIGHT_VOLUME_OFFS = 16'h0325;
    localparam logic [ADDR_W-1:0] MIC_DATA_PAD_PULLDOWN_OFFS = 16'h0c22;

    localparam int GAIN_CODE_LSB = 0;
    localparam int GAIN_CODE_W = 8;
    localparam int MUTE_BIT = 8;
    localparam int UPDATE_STROBE_BIT = 9;

    localparam logic [7:0] GAIN_CODE_RESET = 8'h80;
    localparam logic       MUTE_RESET = 1'b1;
    localparam logic [2:0] PULLDOWN_RESET = 3'h0;

    // fine steps of 0.125 dB per 0.5 dB code step
    localparam int FINE_SHIFT = 2;
    localparam int STEPS_PER_6DB = 48;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAMP_BASE_NS = 500000;
    localparam int RAMP_BASE_STEP_CYCLES = RAMP_BASE_NS / CLK_PERIOD_NS / STEPS_PER_6DB;
    localparam int TICK_CNT_W = 11;
    localparam int MULT_W = 6;

    // ticks of the 0.5 ms/6 dB base per fine step, for each ramp rate code
    function automatic logic [MULT_W-1:0] ramp_mult(input logic [2:0] rate);
        case (rate)
            3'h0:    ramp_mult = 6'h00;
            3'h1:    ramp_mult = 6'h01;
            3'h2:    ramp_mult = 6'h02;
            3'h3:    ramp_mult = 6'h04;
            3'h4:    ramp_mult = 6'h08;
            3'h5:    ramp_mult = 6'h10;
            3'h6:    ramp_mult = 6'h1e;
            default: ramp_mult = 6'h3c;
        endcase
    endfunction : ramp_mult
endpackage : volume_ctrl_pkg
`default_nettype wire
